// >>> rtl/icp_map.svh
// Offsets, field positions, reset values and sizes of the instruction cycle core
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH

`define ICP_PC_W 21
`define ICP_PC_RESET 21'h000000
`define ICP_PC_INC 21'h000001
`define ICP_VEC_HIGH 21'h000008
`define ICP_VEC_LOW 21'h000018

`define ICP_SP_W 5
`define ICP_SP_RESET 5'h00
`define ICP_SP_STEP 5'h01
`define ICP_STACK_DEPTH 5'h1F

`define ICP_OP_MSB 15
`define ICP_OP_LSB 12
`define ICP_TARGET_MSB 11
`define ICP_FADDR_MSB 7
`define ICP_INCF_STEP 8'h01

`define ICP_REG_CTRL 8'h00
`define ICP_REG_FLAG 8'h04
`define ICP_REG_ENABLE 8'h08
`define ICP_REG_PRIO 8'h0C
`define ICP_REG_PC 8'h10
`define ICP_REG_STACK 8'h14
`define ICP_REG_TOP 8'h18

`define ICP_CTRL_HIGH_EN 0
`define ICP_CTRL_LOW_EN 1
`define ICP_STK_ASLEEP 8
`define ICP_STK_OVF 9
`define ICP_STK_UNF 10

`endif

// >>> rtl/icp_pkg.sv
// Types shared by the instruction cycle core
package icp_pkg;
  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } icp_phase_type;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_INCF = 4'h1,
    OP_SLEEP = 4'h3,
    OP_RETURN = 4'h4,
    OP_JUMP = 4'hE
  } icp_op_type;
endpackage

// >>> rtl/icp_phase_gen.sv
// Divide-by-four quadrature phase sequencer
`timescale 1ns/1ns
module icp_phase_gen
  import icp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Current phase, one-hot
  output icp_phase_type phase
);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= PH_ONE;
    end else begin
      case (phase)
        PH_ONE: phase <= PH_TWO; // RL1
        PH_TWO: phase <= PH_THREE;
        PH_THREE: phase <= PH_FOUR;
        default: phase <= PH_ONE;
      endcase
    end
  end

  a_phase_order: assert property (@(posedge clk) disable iff (!rstn) // RL1
    (phase == PH_ONE) |=> (phase == PH_TWO) ##1 (phase == PH_THREE) ##1 (phase == PH_FOUR) ##1 (phase == PH_ONE))
    else $error("phases out of order");

endmodule

// >>> rtl/icp_stack.sv
// Hardware return stack memory with registered read
`timescale 1ns/1ns
`include "icp_map.svh"
module icp_stack
  import icp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write port
  input wire logic wrEn,
  input wire logic [`ICP_SP_W-1:0] wrAddr,
  input wire logic [`ICP_PC_W-1:0] wrData,
  // Read port
  input wire logic [`ICP_SP_W-1:0] rdAddr,
  output logic [`ICP_PC_W-1:0] rdData
);

  logic [`ICP_PC_W-1:0] mem [0:`ICP_STACK_DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= `ICP_PC_RESET;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// >>> rtl/icp_core.sv
// Instruction cycle pipeline core: phases, fetch/execute, wake-up vectoring
//
// Summary of operation
// RL1 - Input clock divided by four into four ordered non-overlapping phases.
// RL2 - Program counter increments in phase one, starting every fetch cycle.
// RL3 - Fetched program word latched into instruction register in phase four.
// RL4 - Instruction cycle is four phases; fetch overlaps execute of previous word.
// RL5 - Instruction presented in phase one, decoded and executed in phases two to four.
// RL6 - Data operand read in phase two, result written in phase four.
// RL7 - Instructions that change the program counter take two cycles.
// RL8 - Other instructions take one cycle; branches flush the prefetched word.
// RL9 - Interrupt wake-up with a global enable set loads vector 0008h or 0018h.
// RL10 - Such a wake-up pushes the program counter and advances the stack pointer.
// RL11 - Wake-up is caused by set interrupt flag bits.
// RL12 - High priority uses the lower vector; no enable means resume in sequence.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`include "icp_map.svh"
module icp_core
  import icp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone register slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Program memory
  output logic [`ICP_PC_W-1:0] progAddr,
  input wire logic [15:0] progData,
  // Data memory
  output logic [7:0] dataAddr,
  output logic dataRdEn,
  input wire logic [7:0] dataRdData,
  output logic dataWrEn,
  output logic [7:0] dataWrData,
  // Peripheral interrupt requests, asynchronous
  input wire logic [7:0] periphIrq,
  // Status
  output icp_phase_type phase,
  output logic asleep
);

  logic [`ICP_PC_W-1:0] pc;
  logic [15:0] ir;
  logic irValid;
  logic [`ICP_SP_W-1:0] hwStackPointer;
  logic [`ICP_PC_W-1:0] stackTop;
  logic stackOverflow;
  logic stackUnderflow;
  logic highGlobalIrqEnable;
  logic lowGlobalIrqEnable;
  logic [7:0] peripheralIrqFlag;
  logic [7:0] irqEnable;
  logic [7:0] irqPriority;
  logic [7:0] irqSync1;
  logic [7:0] irqSync2;

  icp_op_type op;
  logic execValid;
  logic atFour;
  logic isJump;
  logic isReturn;
  logic isBranch;
  logic wakeReq;
  logic hiReq;
  logic loReq;
  logic takeHigh;
  logic takeLow;
  logic doVector;
  logic doPush;
  logic doPop;
  logic [`ICP_PC_W-1:0] jumpTarget;
  logic [`ICP_PC_W-1:0] vector;
  logic [`ICP_SP_W-1:0] stackRdAddr;
  logic wbReq;
  logic wbWrite;
  logic [31:0] next_wbDatOut;

  icp_phase_gen u_phase (
    .clk(clk),
    .rstn(rstn),
    .phase(phase)
  );

  // Execute-stage decode
  assign op = icp_op_type'(ir[`ICP_OP_MSB:`ICP_OP_LSB]);
  assign execValid = irValid && !asleep; // RL5
  assign atFour = (phase == PH_FOUR); // RL4
  assign isJump = execValid && (op == OP_JUMP);
  assign isReturn = execValid && (op == OP_RETURN);
  assign isBranch = isJump || isReturn;
  assign jumpTarget = {{(`ICP_PC_W-`ICP_TARGET_MSB-1){1'b0}}, ir[`ICP_TARGET_MSB:0]};

  // Wake-up and vector selection
  assign wakeReq = |(peripheralIrqFlag & irqEnable); // RL11
  assign hiReq = |(peripheralIrqFlag & irqEnable & irqPriority);
  assign loReq = |(peripheralIrqFlag & irqEnable & ~irqPriority);
  assign takeHigh = hiReq && highGlobalIrqEnable; // RL12
  assign takeLow = !takeHigh && loReq && lowGlobalIrqEnable; // RL12
  assign vector = takeHigh ? `ICP_VEC_HIGH : `ICP_VEC_LOW; // RL12
  assign doVector = atFour && asleep && wakeReq && (takeHigh || takeLow); // RL9
  assign doPush = doVector && (hwStackPointer != `ICP_STACK_DEPTH);
  assign doPop = atFour && isReturn && (hwStackPointer != `ICP_SP_RESET);
  assign stackRdAddr = hwStackPointer - `ICP_SP_STEP;

  icp_stack u_stack (
    .clk(clk),
    .rstn(rstn),
    .wrEn(doPush),
    .wrAddr(hwStackPointer),
    .wrData(progAddr),
    .rdAddr(stackRdAddr),
    .rdData(stackTop)
  );

  // Program counter and fetch address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc <= `ICP_PC_RESET;
      progAddr <= `ICP_PC_RESET;
    end else if (phase == PH_ONE && !asleep) begin
      progAddr <= pc; // RL2
      pc <= pc + `ICP_PC_INC; // RL2
    end else if (atFour) begin
      if (doVector) begin
        pc <= vector; // RL9
      end else if (isJump) begin
        pc <= jumpTarget; // RL7
      end else if (isReturn) begin
        pc <= stackTop; // RL7
      end
    end
  end

  // Instruction register and flush
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ir <= 16'h0000;
      irValid <= 1'b0;
    end else if (atFour) begin
      if (doVector) begin
        irValid <= 1'b0; // RL8
      end else if (!asleep) begin
        ir <= progData; // RL3
        irValid <= !isBranch; // RL8
      end
    end
  end

  // Sleep and wake-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asleep <= 1'b0;
    end else if (atFour) begin
      if (asleep && wakeReq) begin
        asleep <= 1'b0; // RL11
      end else if (execValid && op == OP_SLEEP) begin
        asleep <= 1'b1;
      end
    end
  end

  // Hardware stack pointer and error flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hwStackPointer <= `ICP_SP_RESET;
      stackOverflow <= 1'b0;
      stackUnderflow <= 1'b0;
    end else begin
      if (doPush) begin
        hwStackPointer <= hwStackPointer + `ICP_SP_STEP; // RL10
      end else if (doPop) begin
        hwStackPointer <= hwStackPointer - `ICP_SP_STEP;
      end
      if (doVector && !doPush) begin
        stackOverflow <= 1'b1;
      end else if (wbWrite && wbAdr == `ICP_REG_STACK && wbDatIn[`ICP_STK_OVF]) begin
        stackOverflow <= 1'b0;
      end
      if (atFour && isReturn && !doPop) begin
        stackUnderflow <= 1'b1;
      end else if (wbWrite && wbAdr == `ICP_REG_STACK && wbDatIn[`ICP_STK_UNF]) begin
        stackUnderflow <= 1'b0;
      end
    end
  end

  // Data memory access: read in phase two, write in phase four
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataAddr <= 8'h00;
      dataRdEn <= 1'b0;
      dataWrEn <= 1'b0;
      dataWrData <= 8'h00;
    end else begin
      case (phase)
        PH_ONE: begin
          if (execValid && op == OP_INCF) begin
            dataAddr <= ir[`ICP_FADDR_MSB:0];
            dataRdEn <= 1'b1; // RL6
          end
        end
        PH_TWO: begin
          dataRdEn <= 1'b0;
        end
        PH_THREE: begin
          if (execValid && op == OP_INCF) begin
            dataWrData <= dataRdData + `ICP_INCF_STEP;
            dataWrEn <= 1'b1; // RL6
          end
        end
        default: begin
          dataWrEn <= 1'b0;
        end
      endcase
    end
  end

  // Peripheral request synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqSync1 <= 8'h00;
      irqSync2 <= 8'h00;
    end else begin
      irqSync1 <= periphIrq;
      irqSync2 <= irqSync1;
    end
  end

  assign wbReq = wbCyc && wbStb && !wbAck;
  assign wbWrite = wbReq && wbWe && wbSel[0];

  // Interrupt flags: write one to clear, a new request wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peripheralIrqFlag <= 8'h00;
    end else if (wbWrite && wbAdr == `ICP_REG_FLAG) begin
      peripheralIrqFlag <= (peripheralIrqFlag & ~wbDatIn[7:0]) | irqSync2;
    end else begin
      peripheralIrqFlag <= peripheralIrqFlag | irqSync2; // RL11
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highGlobalIrqEnable <= 1'b0;
      lowGlobalIrqEnable <= 1'b0;
      irqEnable <= 8'h00;
      irqPriority <= 8'h00;
    end else if (wbWrite) begin
      if (wbAdr == `ICP_REG_CTRL) begin
        highGlobalIrqEnable <= wbDatIn[`ICP_CTRL_HIGH_EN];
        lowGlobalIrqEnable <= wbDatIn[`ICP_CTRL_LOW_EN];
      end else if (wbAdr == `ICP_REG_ENABLE) begin
        irqEnable <= wbDatIn[7:0];
      end else if (wbAdr == `ICP_REG_PRIO) begin
        irqPriority <= wbDatIn[7:0];
      end
    end
  end

  // Read decode
  always_comb begin
    next_wbDatOut = 32'h00000000;
    if (wbAdr == `ICP_REG_CTRL) begin
      next_wbDatOut[`ICP_CTRL_HIGH_EN] = highGlobalIrqEnable;
      next_wbDatOut[`ICP_CTRL_LOW_EN] = lowGlobalIrqEnable;
    end else if (wbAdr == `ICP_REG_FLAG) begin
      next_wbDatOut[7:0] = peripheralIrqFlag;
    end else if (wbAdr == `ICP_REG_ENABLE) begin
      next_wbDatOut[7:0] = irqEnable;
    end else if (wbAdr == `ICP_REG_PRIO) begin
      next_wbDatOut[7:0] = irqPriority;
    end else if (wbAdr == `ICP_REG_PC) begin
      next_wbDatOut[`ICP_PC_W-1:0] = pc;
    end else if (wbAdr == `ICP_REG_STACK) begin
      next_wbDatOut[`ICP_SP_W-1:0] = hwStackPointer;
      next_wbDatOut[`ICP_STK_ASLEEP] = asleep;
      next_wbDatOut[`ICP_STK_OVF] = stackOverflow;
      next_wbDatOut[`ICP_STK_UNF] = stackUnderflow;
    end else if (wbAdr == `ICP_REG_TOP) begin
      next_wbDatOut[`ICP_PC_W-1:0] = stackTop;
    end
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h00000000;
    end else begin
      wbAck <= wbReq;
      if (wbReq && !wbWe) begin
        wbDatOut <= next_wbDatOut;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_pc_advance: assert property ( // RL2
    (phase == PH_ONE && !asleep) |=> (pc == $past(pc) + `ICP_PC_INC) && (progAddr == $past(pc)))
    else $error("pc did not advance in phase one");

  a_ir_capture: assert property ( // RL3
    (atFour && !asleep && !doVector) |=> (ir == $past(progData)))
    else $error("instruction word not latched in phase four");

  a_cycle_span: assert property ( // RL4
    (phase == PH_ONE && !asleep && !execValid) |-> ##3 atFour)
    else $error("instruction cycle is not four phases");

  a_exec_hold: assert property ( // RL5
    (phase == PH_ONE) |=> $stable(ir) [*3])
    else $error("instruction changed during execute");

  a_data_read: assert property ( // RL6
    dataRdEn |-> (phase == PH_TWO))
    else $error("data read outside phase two");

  a_data_write: assert property ( // RL6
    dataWrEn |-> (phase == PH_FOUR) && (dataWrData == $past(dataRdData) + `ICP_INCF_STEP))
    else $error("data write wrong phase or value");

  a_jump_fetch: assert property ( // RL7
    (atFour && isJump && !asleep) |=> (pc == $past(jumpTarget)) ##1 (progAddr == $past(jumpTarget, 2)))
    else $error("jump target not fetched next cycle");

  a_branch_flush: assert property ( // RL8
    (atFour && isBranch) |=> !irValid ##4 irValid)
    else $error("branch did not flush exactly one word");

  a_vector_high: assert property ( // RL9
    (doVector && takeHigh) |=> (pc == `ICP_VEC_HIGH) && !irValid)
    else $error("high vector not loaded");

  a_vector_low: assert property ( // RL12
    (doVector && !takeHigh) |=> (pc == `ICP_VEC_LOW))
    else $error("low vector not loaded");

  a_stack_push: assert property ( // RL10
    doPush |=> (hwStackPointer == $past(hwStackPointer) + `ICP_SP_STEP) ##1 (stackTop == $past(progAddr, 2)))
    else $error("return address not pushed");

  a_wake_cause: assert property ( // RL11
    $fell(asleep) |-> $past(wakeReq))
    else $error("woke without a flag");

  a_resume_seq: assert property ( // RL12
    (atFour && asleep && wakeReq && !takeHigh && !takeLow) |=> !asleep && irValid && (pc == $past(pc)))
    else $error("did not resume in sequence");

  c_jump: cover property (atFour && isJump);
  c_vector: cover property (doVector && takeHigh);
  c_resume: cover property ($fell(asleep) && !$past(doVector));
  c_return: cover property (doPop);

endmodule

// >>> bench/icp_mem_model.sv
// Program and data memory model facing the core
`timescale 1ns/1ns
`include "icp_map.svh"
module icp_mem_model (
  // Clock
  input wire logic clk,
  // Program side
  input wire logic [`ICP_PC_W-1:0] progAddr,
  output logic [15:0] progData,
  // Data side
  input wire logic [7:0] dataAddr,
  input wire logic dataRdEn,
  output logic [7:0] dataRdData,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrData
);
  logic [15:0] prog [0:255];
  logic [7:0] dmem [0:255];
  initial begin
    progData = 16'h0000;
    dataRdData = 8'h00;
  end
  always @(posedge clk) begin
    progData <= prog[progAddr[7:0]];
  end
  // Answer only after a strobed read; otherwise scrambled
  always @(posedge clk) begin
    if (dataRdEn) begin
      dataRdData <= dmem[dataAddr];
    end else begin
      dataRdData <= ~dataRdData;
    end
  end
  always @(posedge clk) begin
    if (dataWrEn) begin
      dmem[dataAddr] <= dataWrData;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the instruction cycle core
`timescale 1ns/1ns
`include "icp_map.svh"
module testbench
  import icp_pkg::*;
;
  logic clk, rstn, wbCyc, wbStb, wbWe, wbAck, dataRdEn, dataWrEn, asleep;
  logic [7:0] wbAdr, dataAddr, dataRdData, dataWrData, periphIrq;
  logic [3:0] wbSel;
  logic [31:0] wbDatIn, wbDatOut, rd;
  logic [15:0] progData;
  logic [`ICP_PC_W-1:0] progAddr;
  icp_phase_type phase, expPh;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int rdSeen = 0;
  typedef struct {logic [7:0] a; logic w; logic [3:0] s; logic [31:0] d;} icp_row_type;
  icp_row_type rows [0:15];
  logic [`ICP_PC_W-1:0] expPa [0:4] = '{21'h000000, 21'h000001, 21'h000002, 21'h000005, 21'h000006};

  icp_core dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .progAddr(progAddr),
    .progData(progData), .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData), .periphIrq(periphIrq), .phase(phase), .asleep(asleep));
  icp_mem_model mem (.clk(clk), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Strobes must sit in their own phase
  always @(negedge clk) begin
    if (dataRdEn === 1'b1) begin
      rdSeen++;
    end
    if ((dataRdEn === 1'b1 && phase !== PH_TWO) || (dataWrEn === 1'b1 && phase !== PH_FOUR)) begin
      miscompares++;
      $display("CHECK FAILED strobe phase expected matching seen %b", phase);
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDatIn <= d;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wait_cond(input logic [`ICP_PC_W-1:0] pa, input logic sl, input logic byAddr);
    int n;
    n = 0;
    while (((byAddr && progAddr !== pa) || (!byAddr && asleep !== sl)) && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 32'h1, {31'h0, n < 100});
  endtask

  task automatic wake(input logic [31:0] ctrl, input logic [31:0] prio);
    wb(`ICP_REG_FLAG, 1'b1, 4'hF, 32'h0000_0001);
    wb(`ICP_REG_PRIO, 1'b1, 4'hF, prio);
    wb(`ICP_REG_CTRL, 1'b1, 4'hF, ctrl);
    @(posedge clk);
    periphIrq <= 8'h01;
  endtask

  // Drop the request, let the synchroniser drain, then clear the sticky flag
  task automatic settle();
    periphIrq <= 8'h00;
    repeat (3) @(posedge clk);
    wb(`ICP_REG_FLAG, 1'b0, 4'hF, 32'h0);
    chk("sticky flag", 32'h1, rd);
    wb(`ICP_REG_FLAG, 1'b1, 4'hF, 32'h0000_0001);
  endtask

  initial begin
    rstn = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn, periphIrq} = '0;
    for (int i = 0; i < 256; i++) begin
      mem.prog[i] = 16'h0000;
      mem.dmem[i] = 8'h00;
    end
    mem.prog[0] = 16'h1010;
    mem.prog[1] = 16'hE005;
    mem.prog[2] = 16'h1011;
    mem.prog[5] = 16'h3000;
    mem.prog[8] = 16'h3000;
    mem.prog[9] = 16'hE009;
    mem.prog[24] = 16'h3000;
    mem.prog[25] = 16'hE019;
    mem.dmem[16] = 8'h41;
    rows = '{'{8'h08, 1, 4'hF, 32'hA5}, '{8'h08, 0, 4'hF, 32'hA5}, '{8'h0C, 1, 4'hF, 32'h01},
      '{8'h0C, 0, 4'hF, 32'h01}, '{8'h00, 1, 4'hF, 32'h03}, '{8'h00, 0, 4'hF, 32'h03},
      '{8'h1C, 1, 4'hF, 32'hFF}, '{8'h1C, 0, 4'hF, 32'h00}, '{8'h08, 1, 4'hF, 32'h01},
      '{8'h08, 1, 4'hE, 32'h77}, '{8'h08, 0, 4'hF, 32'h01}, '{8'h00, 1, 4'hF, 32'h01},
      '{8'h00, 0, 4'hF, 32'h01}, '{8'h14, 0, 4'hF, 32'h100}, '{8'h04, 0, 4'hF, 32'h00},
      '{8'h10, 0, 4'hF, 32'h07}};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    expPh = PH_TWO;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      chk("phase", 32'(expPh), 32'(phase));
      if (i % 4 == 0) begin
        chk("progAddr", 32'(expPa[i / 4]), 32'(progAddr));
      end
      expPh = icp_phase_type'({expPh[2:0], expPh[3]});
    end
    $display("test pipeline done");
    for (int i = 0; i < 16; i++) begin
      wb(rows[i].a, rows[i].w, rows[i].s, rows[i].d);
      if (!rows[i].w) begin
        chk("register", rows[i].d, rd);
      end
    end
    chk("incf result", 32'h42, 32'(mem.dmem[16]));
    chk("flushed word", 32'h00, 32'(mem.dmem[17]));
    chk("reads", 32'h1, 32'(rdSeen));
    $display("test registers done");
    wake(32'h1, 32'h1);
    wait_cond(21'h000008, 1'b0, 1'b1);
    settle();
    wait_cond('0, 1'b1, 1'b0);
    wb(`ICP_REG_STACK, 1'b0, 4'hF, 32'h0);
    chk("stack", 32'h101, rd);
    wb(`ICP_REG_TOP, 1'b0, 4'hF, 32'h0);
    chk("top", 32'h6, rd);
    wake(32'h2, 32'h0);
    wait_cond(21'h000018, 1'b0, 1'b1);
    settle();
    wait_cond('0, 1'b1, 1'b0);
    wb(`ICP_REG_FLAG, 1'b0, 4'hF, 32'h0);
    chk("flag", 32'h0, rd);
    wb(`ICP_REG_TOP, 1'b0, 4'hF, 32'h0);
    chk("top", 32'h9, rd);
    wake(32'h0, 32'h0);
    wait_cond('0, 1'b0, 1'b0);
    periphIrq <= 8'h00;
    wb(`ICP_REG_STACK, 1'b0, 4'hF, 32'h0);
    chk("stack", 32'h002, rd);
    $display("test wake-up done");
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset phase", 32'(PH_ONE), 32'(phase));
    chk("reset state", 32'h0, {progAddr, asleep, wbAck});
    @(posedge clk);
    rstn <= 1'b1;
    wb(`ICP_REG_CTRL, 1'b0, 4'hF, 32'h0);
    chk("reset ctrl", 32'h0, rd);
    $display("test reset done");
    wrap_up();
  end
endmodule
